// ---- shared/emt_cfg.svh ----
`ifndef EMT_CFG_SVH
`define EMT_CFG_SVH

// ****************************************************************
// Register byte offsets.
// ****************************************************************
`define EMT_OFS_IO_CONTROL   4'h0
`define EMT_OFS_EVENT_FLAGS  4'h4
`define EMT_OFS_IRQ_GATE     4'h8

// ****************************************************************
// Reset values and writable masks.
// ****************************************************************
`define EMT_RST_IO_CONTROL   8'h00
`define EMT_RST_EVENT_FLAGS  4'h0
`define EMT_RST_IRQ_GATE     8'h00
`define EMT_MASK_IO_CONTROL  8'hF9
`define EMT_MASK_IRQ_GATE    8'h3F

// ****************************************************************
// Flag bit positions.
// ****************************************************************
`define EMT_FLAG_INTERVAL_MATCH 0
`define EMT_FLAG_CAPTURE        1
`define EMT_FLAG_EVENT_MATCH    2
`define EMT_FLAG_MULTCLK_MATCH  3

// ****************************************************************
// Bus encodings.
// ****************************************************************
`define EMT_HTRANS_NONSEQ    2'h2
`define EMT_HSIZE_WORD       3'h2

`endif

// ---- shared/emt_pkg.sv ----
package emt_pkg;

  // ****************************************************************
  // Register layouts.
  // ****************************************************************
  typedef struct packed {
    logic       loadSourceSelect;
    logic       correctedClockHalt;
    logic       eventInputGate;
    logic       reloadInhibit;
    logic       counterCorrection;
    logic [1:0] reserved;
    logic       multclkCompareEnable;
  } io_control_t;

  typedef struct packed {
    logic [1:0] reserved;
    logic [1:0] irqTimingField;
    logic       multclkMatchIrqEn;
    logic       eventMatchIrqEn;
    logic       intervalCaptureIrqEn;
    logic       intervalMatchIrqEn;
  } irq_gate_t;

  // ****************************************************************
  // Issue timing of the multiplied-clock compare request.
  // ****************************************************************
  typedef enum logic [1:0] {
    TIMING_NOW    = 2'b00,
    TIMING_FIRST  = 2'b01,
    TIMING_SECOND = 2'b10,
    TIMING_BAD    = 2'b11
  } irq_timing_t;

  typedef enum logic [1:0] {
    ISSUE_IDLE   = 2'b00,
    ISSUE_WAIT2  = 2'b01,
    ISSUE_WAIT1  = 2'b10,
    ISSUE_ACTIVE = 2'b11
  } issue_state_t;

  // ****************************************************************
  // Events from the counter datapath and interrupt request lines.
  // ****************************************************************
  typedef struct packed {
    logic extEvent;
    logic intervalMatch;
    logic eventMatch;
    logic multclkMatch;
    logic sevenMatch;
    logic counterEqual;
  } timer_events_t;

  typedef struct packed {
    logic irqIntervalMatch;
    logic irqCapture;
    logic irqEventMatch;
    logic irqMultclkMatch;
  } irq_lines_t;

endpackage

// ---- rtl/edge_multiplier_timer_control.sv ----
// Decided for this implementation: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "emt_cfg.svh"
// Contract
// - Control bit 7 picks load source: capture register or software load.
// - Control bit 6 halts corrected-clock counter and its clock, holding value.
// - Control bit 5 gates external events; gated off they are ignored.
// - Control bit 4 set keeps reload counter and reload value on capture.
// - Control bit 3 stops counter four when it equals counter three.
// - Control bit 0 enables multiplied-clock compare match detection.
// - Reserved bits read zero; software writes zero there.
// - Software never sets flags; clears by writing zero after reading one.
// - Flag 3 sets on multiplied-clock counter compare match.
// - Timing field 10 lets hardware clear flag 3 on match seven.
// - Flag 2 sets on event counter compare match.
// - Flag 1 sets when an event captures the interval counter.
// - Flag 0 sets on interval counter compare match.
// - A flag requests an interrupt only with its enable bit set.
// - Timing field: now, first event, second event unless match seven.
// - Enable bit 3 gates the multiplied-clock request, timed by field.
// - Enable bit 2 gates the event counter match request.
// - Enable bit 1 gates the interval capture request.
// - Reset clears flag and enable registers to zero.
// - Flag and enable registers accept byte and word accesses.
// - Enable bit 0 gates the interval match request.
// - Reset clears the control register to zero.
module edge_multiplier_timer_control (
  // Clock and reset.
  input  wire logic                   clk,
  input  wire logic                   rstn,
  // AHB-Lite slave.
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic                        hresp,
  output logic [31:0]                 hrdata,
  // Counter datapath.
  input  wire emt_pkg::timer_events_t events,
  output logic                        loadSourceSelect,
  output logic                        correctedClockHalt,
  output logic                        eventGated,
  output logic                        reloadUpdate,
  output logic                        counterFourStop,
  output logic                        multclkMatchValid,
  // Interrupt requests.
  output emt_pkg::irq_lines_t         irq
);

  // ****************************************************************
  // Registers.
  // ****************************************************************
  emt_pkg::io_control_t  ctl_q;
  emt_pkg::irq_gate_t    gate_q;
  logic [3:0]            flags_q;
  logic [3:0]            flags_d;
  logic [3:0]            readOne_q;
  logic [3:0]            readOne_d;
  logic [31:0]           hrdata_q;
  logic                  wrPend_q;
  logic [3:0]            wrAddr_q;
  emt_pkg::issue_state_t issue_q;
  emt_pkg::issue_state_t issue_d;

  // ****************************************************************
  // Bus decode.
  // ****************************************************************
  wire        busReq     = hsel & hready & (htrans == `EMT_HTRANS_NONSEQ);
  wire        lowLane    = (hsize == `EMT_HSIZE_WORD) | (haddr[1:0] == 2'h0);
  wire        rdReq      = busReq & ~hwrite;
  wire        rdStall    = hsel & (htrans == `EMT_HTRANS_NONSEQ)
                         & ~hwrite & wrPend_q;
  wire        rdTake     = rdReq & ~wrPend_q;
  wire        wrTake     = busReq & hwrite & lowLane;
  wire [3:0]  rdAddr     = {haddr[3:2], 2'h0};
  wire        inRange    = (haddr[31:4] == 28'h0000000);
  wire        rdCtl      = inRange & (rdAddr == `EMT_OFS_IO_CONTROL);
  wire        rdFlags    = inRange & (rdAddr == `EMT_OFS_EVENT_FLAGS);
  wire        rdGate     = inRange & (rdAddr == `EMT_OFS_IRQ_GATE);
  wire        wrCtl      = wrPend_q & (wrAddr_q == `EMT_OFS_IO_CONTROL);
  wire        wrFlags    = wrPend_q & (wrAddr_q == `EMT_OFS_EVENT_FLAGS);
  wire        wrGate     = wrPend_q & (wrAddr_q == `EMT_OFS_IRQ_GATE);
  wire        flagsRead  = rdTake & rdFlags;
  wire [31:0] rdValue    = rdCtl   ? {24'h000000, ctl_q} :
                           rdFlags ? {28'h0000000, flags_q} :
                           rdGate  ? {24'h000000, gate_q} : 32'h00000000;

  assign hreadyout = ~rdStall;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  // ****************************************************************
  // Event gating and datapath controls.
  // ****************************************************************
  wire evt = events.extEvent & ctl_q.eventInputGate;
  assign eventGated         = evt;
  assign loadSourceSelect   = ctl_q.loadSourceSelect;
  assign correctedClockHalt = ctl_q.correctedClockHalt;
  assign reloadUpdate       = evt & ~ctl_q.reloadInhibit;
  assign counterFourStop    = ctl_q.counterCorrection
                            & events.counterEqual;
  assign multclkMatchValid  = events.multclkMatch
                            & ctl_q.multclkCompareEnable;

  // ****************************************************************
  // Status flags.
  // ****************************************************************
  wire modeSecond = (gate_q.irqTimingField == emt_pkg::TIMING_SECOND);
  wire [3:0] setFlag = {multclkMatchValid,
                        events.eventMatch,
                        evt,
                        events.intervalMatch};
  wire [3:0] swClear = {4{wrFlags}} & ~hwdata[3:0] & readOne_q;
  wire [3:0] hwClear = {modeSecond & events.sevenMatch, 3'h0};
  assign flags_d   = setFlag | (flags_q & ~(swClear | hwClear));
  assign readOne_d = flagsRead ? flags_q
                   : (readOne_q & flags_d & ~{4{wrFlags}});

  // ****************************************************************
  // Issue timing of the multiplied-clock request.
  // ****************************************************************
  always_comb begin
    issue_d = issue_q;
    case (issue_q)
      emt_pkg::ISSUE_IDLE: begin
        if (setFlag[3]) begin
          case (gate_q.irqTimingField)
            emt_pkg::TIMING_NOW:    issue_d = emt_pkg::ISSUE_ACTIVE;
            emt_pkg::TIMING_FIRST:  issue_d = emt_pkg::ISSUE_WAIT1;
            emt_pkg::TIMING_SECOND: issue_d = emt_pkg::ISSUE_WAIT2;
            default:                issue_d = emt_pkg::ISSUE_IDLE;
          endcase
        end
      end
      emt_pkg::ISSUE_WAIT2: begin
        if (events.sevenMatch) begin
          issue_d = emt_pkg::ISSUE_IDLE;
        end else if (evt) begin
          issue_d = emt_pkg::ISSUE_WAIT1;
        end
      end
      emt_pkg::ISSUE_WAIT1: begin
        if (modeSecond & events.sevenMatch) begin
          issue_d = emt_pkg::ISSUE_IDLE;
        end else if (evt) begin
          issue_d = emt_pkg::ISSUE_ACTIVE;
        end
      end
      emt_pkg::ISSUE_ACTIVE: issue_d = emt_pkg::ISSUE_ACTIVE;
      default:               issue_d = emt_pkg::ISSUE_IDLE;
    endcase
    if (!flags_d[3]) begin
      issue_d = emt_pkg::ISSUE_IDLE;
    end
  end

  // ****************************************************************
  // Interrupt requests.
  // ****************************************************************
  wire issued = (issue_q == emt_pkg::ISSUE_ACTIVE);
  assign irq.irqIntervalMatch = flags_q[0] & gate_q.intervalMatchIrqEn;
  assign irq.irqCapture       = flags_q[1] & gate_q.intervalCaptureIrqEn;
  assign irq.irqEventMatch    = flags_q[2] & gate_q.eventMatchIrqEn;
  assign irq.irqMultclkMatch  = flags_q[3] & gate_q.multclkMatchIrqEn
                              & issued;

  // ****************************************************************
  // Sequential logic.
  // ****************************************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 4'h0;
      hrdata_q <= 32'h00000000;
    end else begin
      wrPend_q <= wrTake & inRange;
      wrAddr_q <= rdAddr;
      if (rdTake) begin
        hrdata_q <= rdValue;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctl_q <= `EMT_RST_IO_CONTROL;
    end else if (wrCtl) begin
      ctl_q <= hwdata[7:0] & `EMT_MASK_IO_CONTROL;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gate_q <= `EMT_RST_IRQ_GATE;
    end else if (wrGate) begin
      gate_q <= hwdata[7:0] & `EMT_MASK_IRQ_GATE;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flags_q   <= `EMT_RST_EVENT_FLAGS;
      readOne_q <= 4'h0;
      issue_q   <= emt_pkg::ISSUE_IDLE;
    end else begin
      flags_q   <= flags_d;
      readOne_q <= readOne_d;
      issue_q   <= issue_d;
    end
  end

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  property p_captureSets;
    @(posedge clk) disable iff (!rstn)
    evt |=> flags_q[1];
  endproperty
  a_captureSets: assert property (p_captureSets)
    else $error("capture did not set its flag");

  property p_gateBlocks;
    @(posedge clk) disable iff (!rstn)
    (!ctl_q.eventInputGate && !flags_q[1]) |=> !flags_q[1];
  endproperty
  a_gateBlocks: assert property (p_gateBlocks)
    else $error("gated-off event set the capture flag");

  property p_intervalSets;
    @(posedge clk) disable iff (!rstn)
    events.intervalMatch |=> flags_q[0];
  endproperty
  a_intervalSets: assert property (p_intervalSets)
    else $error("interval match did not set its flag");

  property p_eventSets;
    @(posedge clk) disable iff (!rstn)
    events.eventMatch ##0 wrFlags |=> flags_q[2];
  endproperty
  a_eventSets: assert property (p_eventSets)
    else $error("set lost against a clear");

  property p_multclkOnlyEnabled;
    @(posedge clk) disable iff (!rstn)
    $rose(flags_q[3]) |-> $past(events.multclkMatch)
                          && $past(ctl_q.multclkCompareEnable);
  endproperty
  a_multclkOnlyEnabled: assert property (p_multclkOnlyEnabled)
    else $error("multiplied-clock flag rose without enabled match");

  property p_noSoftwareSet;
    @(posedge clk) disable iff (!rstn)
    $rose(flags_q[0]) |-> $past(events.intervalMatch);
  endproperty
  a_noSoftwareSet: assert property (p_noSoftwareSet)
    else $error("interval flag rose without a match");

  property p_clearNeedsRead;
    @(posedge clk) disable iff (!rstn)
    (wrFlags && flags_q[0] && !readOne_q[0]) |=> flags_q[0];
  endproperty
  a_clearNeedsRead: assert property (p_clearNeedsRead)
    else $error("flag cleared without a prior read as one");

  property p_autoClear;
    @(posedge clk) disable iff (!rstn)
    (modeSecond && events.sevenMatch && !multclkMatchValid) |=> !flags_q[3];
  endproperty
  a_autoClear: assert property (p_autoClear)
    else $error("flag 3 not cleared automatically");

  property p_firstEventTiming;
    @(posedge clk) disable iff (!rstn)
    (gate_q.irqTimingField == emt_pkg::TIMING_FIRST && !flags_q[3]
      && multclkMatchValid) ##1 !evt |=> !irq.irqMultclkMatch;
  endproperty
  a_firstEventTiming: assert property (p_firstEventTiming)
    else $error("request issued before the first event");

  property p_irqGated;
    @(posedge clk) disable iff (!rstn)
    irq.irqCapture |-> gate_q.intervalCaptureIrqEn && flags_q[1];
  endproperty
  a_irqGated: assert property (p_irqGated)
    else $error("capture request without enable");

  property p_eventMatchSets;
    @(posedge clk) disable iff (!rstn)
    events.eventMatch |=> flags_q[2];
  endproperty
  a_eventMatchSets: assert property (p_eventMatchSets)
    else $error("event match did not set its flag");

  property p_multclkSets;
    @(posedge clk) disable iff (!rstn)
    multclkMatchValid |=> flags_q[3];
  endproperty
  a_multclkSets: assert property (p_multclkSets)
    else $error("multiplied-clock match did not set its flag");

  property p_intervalIrq;
    @(posedge clk) disable iff (!rstn)
    (events.intervalMatch && gate_q.intervalMatchIrqEn && !wrGate)
      |=> irq.irqIntervalMatch;
  endproperty
  a_intervalIrq: assert property (p_intervalIrq)
    else $error("enabled interval match raised no request");

  property p_eventIrq;
    @(posedge clk) disable iff (!rstn)
    (events.eventMatch && gate_q.eventMatchIrqEn && !wrGate)
      |=> irq.irqEventMatch;
  endproperty
  a_eventIrq: assert property (p_eventIrq)
    else $error("enabled event match raised no request");

  property p_multclkNow;
    @(posedge clk) disable iff (!rstn)
    (gate_q.irqTimingField == emt_pkg::TIMING_NOW && !flags_q[3]
      && gate_q.multclkMatchIrqEn && !wrGate && multclkMatchValid)
      |=> irq.irqMultclkMatch;
  endproperty
  a_multclkNow: assert property (p_multclkNow)
    else $error("immediate multiplied-clock request missing");

  property p_sevenSuppress;
    @(posedge clk) disable iff (!rstn)
    (modeSecond && issue_q != emt_pkg::ISSUE_ACTIVE && events.sevenMatch
      && !multclkMatchValid && !wrGate) |=> !irq.irqMultclkMatch;
  endproperty
  a_sevenSuppress: assert property (p_sevenSuppress)
    else $error("request issued after match seven");

  property p_resetValues;
    @(posedge clk)
    $rose(rstn) |-> (ctl_q == `EMT_RST_IO_CONTROL)
                    && (gate_q == `EMT_RST_IRQ_GATE)
                    && (flags_q == `EMT_RST_EVENT_FLAGS);
  endproperty
  a_resetValues: assert property (p_resetValues)
    else $error("registers left reset with non-zero values");

  c_swClear: cover property (@(posedge clk) disable iff (!rstn)
    flagsRead ##1 (wrFlags && (swClear != 4'h0)));
  c_secondEvent: cover property (@(posedge clk) disable iff (!rstn)
    (issue_q == emt_pkg::ISSUE_WAIT1) && modeSecond && evt);
  c_readStall: cover property (@(posedge clk) disable iff (!rstn)
    rdStall);
  c_nowIssue: cover property (@(posedge clk) disable iff (!rstn)
    issued && (gate_q.irqTimingField == emt_pkg::TIMING_NOW));
  c_sevenAbort: cover property (@(posedge clk) disable iff (!rstn)
    modeSecond && events.sevenMatch && flags_q[3]);

endmodule

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
`include "emt_cfg.svh"
module tb_top;
  // ********
  // Bench signals.
  // ********
  logic                   clk;
  logic                   rstn;
  logic                   hsel;
  logic [31:0]            haddr;
  logic [1:0]             htrans;
  logic                   hwrite;
  logic [2:0]             hsize;
  logic [31:0]            hwdata;
  logic                   hreadyout;
  logic                   hresp;
  logic [31:0]            hrdata;
  emt_pkg::timer_events_t events;
  logic                   loadSourceSelect;
  logic                   correctedClockHalt;
  logic                   eventGated;
  logic                   reloadUpdate;
  logic                   counterFourStop;
  logic                   multclkMatchValid;
  emt_pkg::irq_lines_t    irq;
  logic [31:0]            rd;
  int                     mismatches;
  int                     n_compared;

  localparam logic [31:0] A_CTL = {28'h0000000, `EMT_OFS_IO_CONTROL};
  localparam logic [31:0] A_FLG = {28'h0000000, `EMT_OFS_EVENT_FLAGS};
  localparam logic [31:0] A_GATE = {28'h0000000, `EMT_OFS_IRQ_GATE};
  localparam logic [31:0] A_NONE = 32'h0000000C;
  localparam emt_pkg::timer_events_t E_NONE = 6'h00;
  localparam emt_pkg::timer_events_t E_EXT = 6'h20;
  localparam emt_pkg::timer_events_t E_IM = 6'h10;
  localparam emt_pkg::timer_events_t E_EM = 6'h08;
  localparam emt_pkg::timer_events_t E_MM = 6'h04;
  localparam emt_pkg::timer_events_t E_SEV = 6'h02;
  localparam emt_pkg::timer_events_t E_EQ = 6'h01;

  edge_multiplier_timer_control dut_u (
    .clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .events(events),
    .loadSourceSelect(loadSourceSelect),
    .correctedClockHalt(correctedClockHalt),
    .eventGated(eventGated), .reloadUpdate(reloadUpdate),
    .counterFourStop(counterFourStop),
    .multclkMatchValid(multclkMatchValid), .irq(irq)
  );

  always #50 clk = ~clk;

  // ********
  // Checking and bus tasks.
  // ********
  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out;
    $display("Compared %0d mismatched %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic wait_rdy;
    int k;
    k = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1 && k < 64) begin
      k++;
      @(posedge clk);
    end
    if (k >= 64) begin
      mismatches++;
      close_out;
    end
  endtask

  task automatic xfer(input logic wr_en, input logic [31:0] a,
                      input logic [31:0] wd,
                      input emt_pkg::timer_events_t ev);
    haddr  <= a;
    htrans <= `EMT_HTRANS_NONSEQ;
    hwrite <= wr_en;
    wait_rdy;
    htrans <= 2'h0;
    hwdata <= wd;
    events <= ev;
    wait_rdy;
    rd = hrdata;
    chk("hresp", {31'h0, hresp}, 32'h0);
    if (ev != E_NONE) events <= E_NONE;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, E_NONE);
  endtask

  task automatic rdchk(input string what, input logic [31:0] a,
                       input logic [31:0] exp);
    xfer(1'b0, a, 32'h0, E_NONE);
    chk(what, rd, exp);
  endtask

  task automatic clr_all;
    xfer(1'b0, A_FLG, 32'h0, E_NONE);
    wr(A_FLG, 32'h0);
  endtask

  task automatic pulse(input emt_pkg::timer_events_t ev);
    events <= ev;
    @(posedge clk);
    events <= E_NONE;
    repeat (2) @(posedge clk);
  endtask

  task automatic comb(input emt_pkg::timer_events_t ev,
                      input logic [3:0] exp);
    events <= ev;
    @(negedge clk);
    chk("datapath", {28'h0, eventGated, reloadUpdate, counterFourStop,
        multclkMatchValid}, {28'h0, exp});
    @(posedge clk);
    events <= E_NONE;
    @(posedge clk);
  endtask

  task automatic lvl(input logic [1:0] exp);
    @(negedge clk);
    chk("levels", {30'h0, loadSourceSelect, correctedClockHalt},
        {30'h0, exp});
    @(posedge clk);
  endtask

  task automatic chkirq(input logic [3:0] exp);
    @(negedge clk);
    chk("irq", {28'h0, irq}, {28'h0, exp});
    @(posedge clk);
  endtask

  // ********
  // Watchdog.
  // ********
  initial begin
    #1000000;
    mismatches++;
    close_out;
  end

  // ********
  // Test sequence.
  // ********
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = `EMT_HSIZE_WORD;
    hwdata = 32'h0;
    events = E_NONE;
    mismatches = 0;
    n_compared = 0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    chkirq(4'h0);
    rdchk("control", A_CTL, 32'h0);
    rdchk("flags", A_FLG, 32'h0);
    rdchk("gate", A_GATE, 32'h0);
    $display("Test reset done");
    wr(A_CTL, 32'hFF);
    rdchk("control", A_CTL, 32'hF9);
    lvl(2'b11);
    comb(E_EXT, 4'h8);
    comb(E_EQ, 4'h2);
    comb(E_MM, 4'h1);
    wr(A_CTL, 32'h20);
    lvl(2'b00);
    comb(E_EXT | E_EQ | E_MM, 4'hC);
    wr(A_CTL, 32'h00);
    comb(E_EXT, 4'h0);
    clr_all;
    wr(A_NONE, 32'hFF);
    rdchk("unmapped", A_NONE, 32'h0);
    rdchk("control", A_CTL, 32'h0);
    $display("Test control done");
    pulse(E_EXT | E_MM);
    rdchk("flags", A_FLG, 32'h0);
    wr(A_FLG, 32'hFF);
    rdchk("flags", A_FLG, 32'h0);
    wr(A_CTL, 32'h21);
    pulse(E_IM);
    rdchk("flags", A_FLG, 32'h1);
    pulse(E_EXT);
    rdchk("flags", A_FLG, 32'h3);
    pulse(E_EM);
    rdchk("flags", A_FLG, 32'h7);
    pulse(E_MM);
    rdchk("flags", A_FLG, 32'hF);
    wr(A_FLG, 32'hFF);
    rdchk("flags", A_FLG, 32'hF);
    wr(A_FLG, 32'hFF);
    wr(A_FLG, 32'h0);
    rdchk("flags", A_FLG, 32'hF);
    wr(A_FLG, 32'h0E);
    rdchk("flags", A_FLG, 32'hE);
    pulse(E_IM);
    rdchk("flags", A_FLG, 32'hF);
    xfer(1'b1, A_FLG, 32'h0, E_IM | E_EM);
    rdchk("flags", A_FLG, 32'h5);
    clr_all;
    rdchk("flags", A_FLG, 32'h0);
    $display("Test flags done");
    wr(A_GATE, 32'h07);
    pulse(E_IM | E_EXT | E_EM);
    chkirq(4'hE);
    wr(A_GATE, 32'h05);
    chkirq(4'hA);
    wr(A_GATE, 32'h02);
    chkirq(4'h4);
    wr(A_GATE, 32'hFF);
    rdchk("gate", A_GATE, 32'h3F);
    clr_all;
    chkirq(4'h0);
    $display("Test gating done");
    for (int t = 0; t < 4; t++) begin
      wr(A_GATE, 32'h08 | (t << 4));
      pulse(E_MM);
      chkirq({3'h0, t == 0});
      pulse(E_EXT);
      chkirq({3'h0, t < 2});
      pulse(E_EXT);
      chkirq({3'h0, t < 3});
      clr_all;
      chkirq(4'h0);
    end
    wr(A_GATE, 32'h28);
    pulse(E_MM);
    pulse(E_EXT);
    pulse(E_SEV);
    rdchk("flags", A_FLG, 32'h2);
    pulse(E_EXT);
    chkirq(4'h0);
    clr_all;
    $display("Test timing done");
    close_out;
  end
endmodule
